//--- hdl/pdt_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module pdt_ctl
  import pdt_pkg::*;
#(
  parameter int LONG_CYCLES = 32768,
  parameter int SHORT_CYCLES = 1024,
  parameter int MASTERS = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // delayed completion events
  input wire pdt_cpl_type cpl_in,
  // config cycle in and out
  input wire pdt_cfg_type cfg_in,
  output pdt_cfg_type cfg_out,
  // arbiter
  input wire logic [MASTERS-1:0] arb_req,
  input wire logic arb_bus_idle,
  output logic [MASTERS:0] arb_park_gnt,
  // prefetch controls
  output logic dyn_prefetch_en,
  output logic cpl_predict_en,
  output logic [1:0] read_multiple_mode,
  output logic full_prefetch,
  output logic keep_leftover,
  output logic cpl_discard,
  // error and interrupt
  output logic err_msg_req,
  output logic system_error_out_n,
  output logic irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] bridge_control_upper_reg;
  logic [15:0] pci_prefetch_control_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [PDT_TIMER_W-1:0] timer_reg;
  logic timer_run_reg;
  logic [MASTERS:0] last_gnt_reg;
  logic ack_reg;
  logic [PDT_TIMER_W-1:0] limit;
  logic expire;
  logic wr_hit;
  logic [1:0] rm;
  logic conv_hit;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_hit = avs_write & ack_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      avs_readdata <= PDT_UNMAPPED_DATA;
    else if (avs_read & ~ack_reg)
    begin
      if (hit(avs_address, PDT_OFS_BRIDGE))
        avs_readdata <= bridge_control_upper_reg;
      else if (hit(avs_address, PDT_OFS_PREFETCH))
        avs_readdata <= {16'h0000, pci_prefetch_control_reg};
      else if (hit(avs_address, PDT_OFS_IRQ_STATUS))
        avs_readdata <= {30'h00000000, irq_status_reg};
      else if (hit(avs_address, PDT_OFS_IRQ_ENABLE))
        avs_readdata <= {30'h00000000, irq_enable_reg};
      else
        avs_readdata <= PDT_UNMAPPED_DATA;
    end
  end

  // ----------------------------------------
  // bridge control upper bits
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      bridge_control_upper_reg <= PDT_BRIDGE_RESET;
    else
    begin
      if (wr_hit && hit(avs_address, PDT_OFS_BRIDGE) && avs_byteenable[3])
      begin
        bridge_control_upper_reg[PDT_BIT_PRI_SEL] <= avs_writedata[PDT_BIT_PRI_SEL];
        bridge_control_upper_reg[PDT_BIT_SEC_SEL] <= avs_writedata[PDT_BIT_SEC_SEL];
        bridge_control_upper_reg[PDT_BIT_ERR_EN] <= avs_writedata[PDT_BIT_ERR_EN];
      end
      // set wins over write-one clear
      if (expire)
        bridge_control_upper_reg[PDT_BIT_TO_STATUS] <= 1'b1;
      else if (wr_hit && hit(avs_address, PDT_OFS_BRIDGE) && avs_byteenable[3]
               && avs_writedata[PDT_BIT_TO_STATUS])
        bridge_control_upper_reg[PDT_BIT_TO_STATUS] <= 1'b0;
    end
  end

  // ----------------------------------------
  // prefetch control
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      pci_prefetch_control_reg <= PDT_PREFETCH_RESET;
    else if (wr_hit && hit(avs_address, PDT_OFS_PREFETCH) && avs_byteenable[0])
      pci_prefetch_control_reg[5:0] <= avs_writedata[5:0];
  end

  assign rm = pci_prefetch_control_reg[PDT_BIT_RM_LO +: 2];
  assign read_multiple_mode = rm;
  assign dyn_prefetch_en = ~pci_prefetch_control_reg[PDT_BIT_DYN_DIS];
  assign cpl_predict_en = ~pci_prefetch_control_reg[PDT_BIT_PRED_DIS];
  assign full_prefetch = (rm != PDT_RM_ONE_LINE);

  always_comb
  begin
    unique case (rm)
      PDT_RM_KEEP_OWN: keep_leftover = cpl_in.own_disc;
      PDT_RM_KEEP_ANY: keep_leftover = cpl_in.own_disc | cpl_in.master_term;
      default: keep_leftover = 1'b0;
    endcase
  end

  // ----------------------------------------
  // discard timer
  // ----------------------------------------
  assign limit = bridge_control_upper_reg[PDT_BIT_SEC_SEL]
               ? PDT_TIMER_W'(SHORT_CYCLES - 1)
               : PDT_TIMER_W'(LONG_CYCLES - 1);
  assign expire = timer_run_reg & ~cpl_in.repeat_seen & (timer_reg == limit);
  assign cpl_discard = expire;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timer_run_reg <= 1'b0;
      timer_reg <= '0;
    end
    else if (cpl_in.repeat_seen || expire)
    begin
      timer_run_reg <= 1'b0;
      timer_reg <= '0;
    end
    else if (cpl_in.avail && !timer_run_reg)
    begin
      timer_run_reg <= 1'b1;
      timer_reg <= '0;
    end
    else if (timer_run_reg)
      timer_reg <= timer_reg + 1'b1;
  end

  // ----------------------------------------
  // error message
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      err_msg_req <= 1'b0;
      system_error_out_n <= 1'b1;
    end
    else
    begin
      err_msg_req <= expire & bridge_control_upper_reg[PDT_BIT_ERR_EN];
      system_error_out_n <= ~(expire & bridge_control_upper_reg[PDT_BIT_ERR_EN]);
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_status_reg <= 2'h0;
      irq_enable_reg <= 2'h0;
    end
    else
    begin
      if (wr_hit && hit(avs_address, PDT_OFS_IRQ_ENABLE))
        irq_enable_reg <= avs_writedata[1:0];
      irq_status_reg <= (irq_status_reg &
        ~((wr_hit && hit(avs_address, PDT_OFS_IRQ_CLEAR)) ? avs_writedata[1:0] : 2'h0))
        | {conv_hit, expire};
    end
  end
  assign irq = |(irq_status_reg & irq_enable_reg);

  // ----------------------------------------
  // config conversion
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_out <= '0;
    else
    begin
      cfg_out <= cfg_in;
      if (pci_prefetch_control_reg[PDT_BIT_CFG_CONV] && !cfg_in.type1
          && (cfg_in.addr[31:28] == 4'hf))
      begin
        cfg_out.type1 <= 1'b1;
        cfg_out.addr[0] <= 1'b1;
      end
    end
  end

  // conversion really taken, for the status bit
  assign conv_hit = cfg_in.valid & pci_prefetch_control_reg[PDT_BIT_CFG_CONV] & ~cfg_in.type1
                  & (cfg_in.addr[31:28] == 4'hf);

  // ----------------------------------------
  // arbiter parking
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      last_gnt_reg <= (MASTERS+1)'(1);
    else if (|arb_req)
      last_gnt_reg <= {arb_req & (~arb_req + 1'b1), 1'b0};
  end
  assign arb_park_gnt = !arb_bus_idle ? '0
    : pci_prefetch_control_reg[PDT_BIT_PARK] ? (MASTERS+1)'(1) : last_gnt_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seq_timer_start;
    cpl_in.avail && !timer_run_reg && !cpl_in.repeat_seen;
  endsequence

  sequence seq_conv;
    cfg_in.valid && pci_prefetch_control_reg[PDT_BIT_CFG_CONV] && !cfg_in.type1
    && cfg_in.addr[31:28] == 4'hf;
  endsequence

  sequence seq_one_then_idle;
    $onehot(arb_req)
    ##1 (arb_bus_idle && arb_req == '0 && !pci_prefetch_control_reg[PDT_BIT_PARK]);
  endsequence

  sequence seq_bus_wait;
    (avs_read || avs_write) && !ack_reg;
  endsequence

  AST_STATUS_SET: assert property (@(posedge clk) disable iff (rst)
    expire |=> bridge_control_upper_reg[PDT_BIT_TO_STATUS])
    else $error("status not set on expiry");
  AST_STATUS_CLR: assert property (@(posedge clk) disable iff (rst)
    wr_hit && hit(avs_address, PDT_OFS_BRIDGE) && avs_byteenable[3]
    && avs_writedata[PDT_BIT_TO_STATUS] && !expire
    |=> !bridge_control_upper_reg[PDT_BIT_TO_STATUS])
    else $error("status not cleared");
  AST_IRQ_EXP: assert property (@(posedge clk) disable iff (rst)
    expire |=> irq_status_reg[0])
    else $error("expiry status bit not set");
  AST_ERR_MSG: assert property (@(posedge clk) disable iff (rst)
    expire && bridge_control_upper_reg[PDT_BIT_ERR_EN] |=> err_msg_req)
    else $error("no error message on expiry");
  AST_ERR_OFF: assert property (@(posedge clk) disable iff (rst)
    expire && !bridge_control_upper_reg[PDT_BIT_ERR_EN] |=> !err_msg_req)
    else $error("error message while disabled");
  AST_ERR_PIN: assert property (@(posedge clk) disable iff (rst)
    system_error_out_n == !err_msg_req)
    else $error("error pin disagrees");
  AST_NO_ERR: assert property (@(posedge clk) disable iff (rst)
    !$past(expire) |-> !err_msg_req)
    else $error("spurious error message");
  AST_SHORT: assert property (@(posedge clk) disable iff (rst)
    expire && bridge_control_upper_reg[PDT_BIT_SEC_SEL] |->
    timer_reg == PDT_TIMER_W'(SHORT_CYCLES - 1))
    else $error("short expiry count wrong");
  AST_LONG: assert property (@(posedge clk) disable iff (rst)
    expire && !bridge_control_upper_reg[PDT_BIT_SEC_SEL] |->
    timer_reg == PDT_TIMER_W'(LONG_CYCLES - 1))
    else $error("long expiry count wrong");
  AST_TIMER_START: assert property (@(posedge clk) disable iff (rst)
    seq_timer_start |=> timer_run_reg && timer_reg == '0)
    else $error("timer did not start");
  AST_PARK_OWN: assert property (@(posedge clk) disable iff (rst)
    arb_bus_idle && pci_prefetch_control_reg[PDT_BIT_PARK] |-> arb_park_gnt[0])
    else $error("not parked on own port");
  AST_PARK_LAST: assert property (@(posedge clk) disable iff (rst)
    seq_one_then_idle |-> arb_park_gnt == {$past(arb_req), 1'b0})
    else $error("not parked on last master");
  AST_IDLE_GNT: assert property (@(posedge clk) disable iff (rst)
    !arb_bus_idle |-> arb_park_gnt == '0)
    else $error("park grant while bus busy");
  AST_DYN: assert property (@(posedge clk) disable iff (rst)
    dyn_prefetch_en != pci_prefetch_control_reg[PDT_BIT_DYN_DIS])
    else $error("dynamic prefetch wrong");
  AST_PRED: assert property (@(posedge clk) disable iff (rst)
    cpl_predict_en != pci_prefetch_control_reg[PDT_BIT_PRED_DIS])
    else $error("prediction wrong");
  AST_CONV: assert property (@(posedge clk) disable iff (rst)
    cfg_in.valid && pci_prefetch_control_reg[PDT_BIT_CFG_CONV] && cfg_in.addr[31:28] == 4'hf
    |=> cfg_out.type1)
    else $error("config not converted");
  AST_CONV_ADDR: assert property (@(posedge clk) disable iff (rst)
    seq_conv |=> cfg_out.addr[0] && cfg_out.type1)
    else $error("converted address bit 0 wrong");
  AST_CONV_SEEN: assert property (@(posedge clk) disable iff (rst)
    seq_conv |=> irq_status_reg[1])
    else $error("conversion status not set");
  AST_NO_CONV: assert property (@(posedge clk) disable iff (rst)
    cfg_in.valid && !pci_prefetch_control_reg[PDT_BIT_CFG_CONV] && !cfg_in.type1
    |=> !cfg_out.type1)
    else $error("converted while disabled");
  AST_ONE_LINE: assert property (@(posedge clk) disable iff (rst)
    rm == PDT_RM_ONE_LINE |-> !full_prefetch && !keep_leftover)
    else $error("one line mode wrong");
  AST_FULL_MODES: assert property (@(posedge clk) disable iff (rst)
    rm != PDT_RM_ONE_LINE |-> full_prefetch)
    else $error("full prefetch missing");
  AST_NO_KEEP_FULL: assert property (@(posedge clk) disable iff (rst)
    rm == PDT_RM_FULL |-> !keep_leftover)
    else $error("mode 10 kept data");
  AST_KEEP_OWN: assert property (@(posedge clk) disable iff (rst)
    rm == PDT_RM_KEEP_OWN && cpl_in.master_term && !cpl_in.own_disc |-> !keep_leftover)
    else $error("mode 01 kept on master stop");
  AST_KEEP_ANY: assert property (@(posedge clk) disable iff (rst)
    rm == PDT_RM_KEEP_ANY && cpl_in.master_term |-> keep_leftover)
    else $error("mode 11 not kept");
  AST_STOP: assert property (@(posedge clk) disable iff (rst)
    cpl_in.repeat_seen |=> !timer_run_reg)
    else $error("timer not stopped");
  AST_BUS_WAIT: assert property (@(posedge clk) disable iff (rst)
    seq_bus_wait |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait cycle wrong");
endmodule // pdt_ctl
`default_nettype wire

//--- hdl/pdt_pkg.sv
// Functional notes
// - secondary timer: 2^15 cycles, 2^10 when set
// - primary select bit stored, has no effect
// - expiry drop sets status; write one clears
// - expiry with enable raises error message
// - park on last master or own port
// - dynamic prefetch control off when bit set
// - completion prediction off when bit set
// - convert type0 to type1 if top nibble ones
// - converted cycles set address bit 0 to one, type1
// - mode 00 one line, 10 full, reset 10
// - mode 01 keeps data on own disconnect
// - mode 11 keeps data on any termination
package pdt_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] PDT_OFS_BRIDGE = 8'h3c;
  localparam logic [7:0] PDT_OFS_PREFETCH = 8'h40;
  localparam logic [7:0] PDT_OFS_IRQ_STATUS = 8'h80;
  localparam logic [7:0] PDT_OFS_IRQ_CLEAR = 8'h84;
  localparam logic [7:0] PDT_OFS_IRQ_ENABLE = 8'h88;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PDT_BIT_PRI_SEL = 24;
  localparam int PDT_BIT_SEC_SEL = 25;
  localparam int PDT_BIT_TO_STATUS = 26;
  localparam int PDT_BIT_ERR_EN = 27;
  localparam int PDT_BIT_PARK = 0;
  localparam int PDT_BIT_DYN_DIS = 1;
  localparam int PDT_BIT_PRED_DIS = 2;
  localparam int PDT_BIT_CFG_CONV = 3;
  localparam int PDT_BIT_RM_LO = 4;
  // ----------------------------------------
  // reset values and modes
  // ----------------------------------------
  localparam logic [1:0] PDT_RM_ONE_LINE = 2'h0;
  localparam logic [1:0] PDT_RM_KEEP_OWN = 2'h1;
  localparam logic [1:0] PDT_RM_FULL = 2'h2;
  localparam logic [1:0] PDT_RM_KEEP_ANY = 2'h3;
  localparam logic [15:0] PDT_PREFETCH_RESET = 16'h0020;
  localparam logic [31:0] PDT_BRIDGE_RESET = 32'h00000000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int PDT_LONG_EXP = 15;
  localparam int PDT_SHORT_EXP = 10;
  localparam int PDT_TIMER_W = 16;
  localparam logic [31:0] PDT_UNMAPPED_DATA = 32'h00000000;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic type1;
  } pdt_cfg_type;

  typedef struct packed {
    logic avail;
    logic repeat_seen;
    logic own_disc;
    logic master_term;
  } pdt_cpl_type;
endpackage

//--- test/pdt_pci_masters.sv
`timescale 1ns/10ps
`default_nettype none
module pdt_pci_masters
  import pdt_pkg::*;
#(
  parameter int MASTERS = 4
)(
  // clock
  input wire logic clk,
  // toward the bridge
  output pdt_cpl_type cpl_in,
  output pdt_cfg_type cfg_in,
  output logic [MASTERS-1:0] arb_req,
  output logic arb_bus_idle
);
  // ----------
  // bus masters
  // ----------
  initial
  begin
    cpl_in = '0;
    cfg_in = '0;
    arb_req = '0;
    arb_bus_idle = 1'b1;
  end
  task automatic set_cpl(input logic [3:0] ev);
    @(posedge clk);
    cpl_in <= ev;
  endtask
  task automatic cpl_event(input logic [3:0] ev);
    set_cpl(ev);
    set_cpl(4'h0);
  endtask
  // config cycle, other bits in type 1 layout
  task automatic cfg_cycle(input logic [31:0] a, input logic t1);
    @(posedge clk);
    cfg_in <= {1'b1, a, t1};
    @(posedge clk);
    cfg_in <= '0;
  endtask
  task automatic request(input logic [MASTERS-1:0] r);
    @(posedge clk);
    arb_req <= r;
    arb_bus_idle <= (r == '0);
  endtask
endmodule // pdt_pci_masters
`default_nettype wire

//--- test/pdt_ctl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pdt_ctl_tb_top;
  import pdt_pkg::*;
  localparam int LONG = 64;
  localparam int SHORT = 16;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, dyn_prefetch_en, cpl_predict_en;
  logic full_prefetch, keep_leftover, cpl_discard, err_msg_req, system_error_out_n, irq;
  logic arb_bus_idle;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, pref, brg, a;
  logic [1:0] read_multiple_mode;
  logic [4:0] arb_park_gnt;
  logic [3:0] arb_req, avs_byteenable, be;
  pdt_cpl_type cpl_in;
  pdt_cfg_type cfg_in, cfg_out;
  int error_cnt = 0;
  int checks_done = 0;
  int n, cv;
  integer seed = 32'h41a32edb;
  pdt_ctl #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT), .MASTERS(4)) uut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpl_in(cpl_in),
    .cfg_in(cfg_in), .cfg_out(cfg_out), .arb_req(arb_req), .arb_bus_idle(arb_bus_idle),
    .arb_park_gnt(arb_park_gnt), .dyn_prefetch_en(dyn_prefetch_en),
    .cpl_predict_en(cpl_predict_en), .read_multiple_mode(read_multiple_mode),
    .full_prefetch(full_prefetch), .keep_leftover(keep_leftover),
    .cpl_discard(cpl_discard), .err_msg_req(err_msg_req),
    .system_error_out_n(system_error_out_n), .irq(irq));
  pdt_pci_masters #(.MASTERS(4)) model (.clk(clk), .cpl_in(cpl_in), .cfg_in(cfg_in),
    .arb_req(arb_req), .arb_bus_idle(arb_bus_idle));
  // ----------
  // helpers
  // ----------
  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 50)
      chk("waitrequest", 0, 1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic timer(input int lim, input logic err);
    model.cpl_event(4'b1000);
    for (n = 1; n < lim + 8; n++)
    begin
      @(negedge clk);
      if (cpl_discard === 1'b1)
        break;
    end
    chk("expiry cycles", lim, n);
    @(negedge clk);
    chk("err msg", err, err_msg_req);
    chk("error pin", !err, system_error_out_n);
  endtask
  // ----------
  // stimulus
  // ----------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    be = 4'hf;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, PDT_OFS_PREFETCH, 0);
    chk("prefetch reset", PDT_PREFETCH_RESET, q);
    bus(0, 8'h10, 0);
    chk("unmapped", PDT_UNMAPPED_DATA, q);
    for (int m = 0; m < 4; m++)
    begin
      pref = (m << 4) | ($random(seed) & 32'h7);
      bus(1, PDT_OFS_PREFETCH, pref);
      bus(0, PDT_OFS_PREFETCH, 0);
      chk("prefetch reg", pref, q);
      chk("full", m != 0, full_prefetch);
      chk("rm mode", m, read_multiple_mode);
      chk("dynamic", !pref[1], dyn_prefetch_en);
      chk("predict", !pref[2], cpl_predict_en);
      model.set_cpl(4'b0010);
      @(negedge clk);
      chk("keep own", m % 2, keep_leftover);
      model.set_cpl(4'b0001);
      @(negedge clk);
      chk("keep any", m == 3, keep_leftover);
      model.set_cpl(4'b0000);
    end
    bus(1, PDT_OFS_IRQ_ENABLE, 1);
    brg = 32'h0a000000;
    bus(1, PDT_OFS_BRIDGE, brg);
    timer(SHORT, 1);
    bus(0, PDT_OFS_BRIDGE, 0);
    chk("status set", brg | 32'h04000000, q);
    chk("irq set", 1, irq);
    bus(1, PDT_OFS_BRIDGE, brg | 32'h04000000);
    bus(1, PDT_OFS_IRQ_CLEAR, 1);
    bus(0, PDT_OFS_BRIDGE, 0);
    chk("status clear", brg, q);
    chk("irq clear", 0, irq);
    brg = 32'h01000000;
    bus(1, PDT_OFS_BRIDGE, brg);
    timer(LONG, 0);
    model.cpl_event(4'b1000);
    model.cpl_event(4'b0100);
    cv = 0;
    repeat (LONG + 5)
    begin
      @(negedge clk);
      if (cpl_discard !== 1'b0)
        cv = 1;
    end
    chk("repeat stops", 0, cv);
    for (int i = 0; i < 4; i++)
    begin
      bus(1, PDT_OFS_PREFETCH, i == 1 ? 32'h20 : 32'h28);
      a = {i == 2 ? 4'he : 4'hf, 26'($random(seed)), 1'b0, 1'($random(seed))};
      cv = (i == 0) || (i == 3);
      model.cfg_cycle(a, i == 3);
      @(negedge clk);
      chk("cfg type", cv, cfg_out.type1);
      chk("cfg addr", i == 0 ? a | 1 : a, cfg_out.addr);
    end
    bus(0, PDT_OFS_IRQ_STATUS, 0);
    chk("irq status", 3, q);
    bus(1, PDT_OFS_PREFETCH, 32'h20);
    model.request(4'b0100);
    model.request(4'b0000);
    @(negedge clk);
    chk("park last", 5'b01000, arb_park_gnt);
    bus(1, PDT_OFS_PREFETCH, 32'h21);
    @(negedge clk);
    chk("park own", 5'b00001, arb_park_gnt);
    be = 4'h7;
    bus(1, PDT_OFS_BRIDGE, 32'h0a000000);
    be = 4'he;
    bus(1, PDT_OFS_PREFETCH, 32'h28);
    be = 4'hf;
    bus(0, PDT_OFS_BRIDGE, 0);
    chk("bridge lane off", brg | 32'h04000000, q);
    bus(0, PDT_OFS_PREFETCH, 0);
    chk("prefetch lane off", 32'h21, q);
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, PDT_OFS_BRIDGE, 0);
    chk("bridge reset", PDT_BRIDGE_RESET, q);
    bus(0, PDT_OFS_PREFETCH, 0);
    chk("prefetch reset again", PDT_PREFETCH_RESET, q);
    chk("park reset", 5'b00001, arb_park_gnt);
    chk("irq reset", 0, irq);
    stop_test;
  end
endmodule // pdt_ctl_tb_top
`default_nettype wire
